/* hdl/psdws_pkg.sv */
// Constants and carrier types for the partial stop and DMA wakeup sequencer.
// Assumes one 10 MHz clock and synchronous active-low reset.
package psdws_pkg;

  localparam int DMA_CHANNELS = 4;

  // Stop selection encodings.
  localparam logic [1:0] SEL_FULL_STOP = 2'h0;
  localparam logic [1:0] SEL_BUS_ALIVE = 2'h1;
  localparam logic [1:0] SEL_FULL_GATE = 2'h2;

  // Interrupt source bit positions.
  localparam int IRQ_ASYNC_SYS = 0;
  localparam int IRQ_SYNC_BUS = 1;

  // Longest time a stage may wait for its acknowledge, in ns.
  localparam int ACK_TIMEOUT_NS = 2000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLOCK_PERIOD_NS;
  localparam int TMR_W = 8;

  typedef enum logic [3:0] {
    ST_RUN = 4'h0,
    ST_STOP_MASTERS = 4'h1,
    ST_STOP_SLAVES = 4'h2,
    ST_STOP_POWER = 4'h3,
    ST_LOW_POWER = 4'h4,
    ST_DMA_AWAKE = 4'h5,
    ST_DMA_DRAIN = 4'h6,
    ST_EXIT = 4'h7
  } psdws_state_t;

  // Clock gates and stop requests handed to the rest of the chip.
  typedef struct packed {
    logic core_clk_en;
    logic sys_clk_en;
    logic bus_clk_en;
    logic master_stop;
    logic sys_slave_stop;
    logic bus_slave_stop;
    logic gen_stop;
    logic reg_stop;
  } psdws_ctrl_t;

  localparam psdws_ctrl_t CTRL_RUN = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

/* hdl/psdws_stage_timer.sv */
// Bounded wait for one stage acknowledge of the stop entry sequence.
// Assumes start is a one-cycle pulse and ack a level from the addressed parties.
`timescale 1ns/1ps
module psdws_stage_timer
  import psdws_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Stage control.
  input wire logic start,
  input wire logic active,
  input wire logic ack,
  // Result.
  output logic done
);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  localparam logic [TMR_W-1:0] LIMIT = TMR_W'(ACK_TIMEOUT_CYC);

  // A stage completes on its acknowledge or when the wait runs out.
  assign cnt_nxt = start ? '0 : (active && cnt_r != LIMIT) ? cnt_r + 1'b1 : cnt_r;
  assign done = active && !start && (ack || cnt_r == LIMIT);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  stage_bound_a: assert property (@(posedge clk) disable iff (!rstn)
    active && !start && !ack && cnt_r == LIMIT |-> done)
    else $error("Stage wait exceeded its limit");

endmodule // psdws_stage_timer

/* hdl/psdws_sequencer.sv */
// Partial stop and DMA wakeup sequencer of the system mode controller.
// Assumes all requests, acknowledges and interrupts are synchronous to CLOCK.
`timescale 1ns/1ps
module psdws_sequencer
  import psdws_pkg::*;
(
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RSTN,
  // Mode requests from the core.
  input wire logic STOP_REQ,
  input wire logic VERY_LOW_POWER_RUN,
  input wire logic COMPUTE_OP,
  input wire logic COMPUTE_IRQ_EXIT,
  input wire logic [1:0] STOP_SEL,
  // DMA wakeup.
  input wire logic [DMA_CHANNELS-1:0] DMA_WAKE_EN,
  input wire logic [DMA_CHANNELS-1:0] DMA_REQ_SYNC,
  input wire logic [DMA_CHANNELS-1:0] DMA_REQ_ASYNC,
  input wire logic DMA_BUSY,
  // Interrupts.
  input wire logic [1:0] IRQ,
  // Acknowledges from stopped parties.
  input wire logic MASTER_ACK,
  input wire logic SLAVE_ACK,
  input wire logic POWER_ACK,
  // Clock gates and stop requests.
  output psdws_ctrl_t CTRL,
  // Status.
  output logic LOW_POWER,
  output logic DMA_AWAKE,
  output logic STOP_ABORT,
  output logic CPU_WAKE
);

  psdws_state_t state_r;
  psdws_state_t state_nxt;
  logic [1:0] sel_r;
  logic [1:0] sel_nxt;
  logic compute_r;
  logic compute_nxt;
  logic vlp_r;
  logic vlp_nxt;
  logic abort_r;
  logic abort_nxt;
  logic wake_r;
  logic wake_nxt;
  psdws_ctrl_t ctrl_r;
  psdws_ctrl_t ctrl_nxt;
  logic [DMA_CHANNELS-1:0] dma_any_ch;
  logic dma_wake;
  logic irq_wake;
  logic entering;
  logic stage_start_r;
  logic stage_start_nxt;
  logic stage_ack;
  logic stage_done;
  logic stage_active;
  logic bus_alive;
  logic full_stop;

  assign dma_any_ch = (DMA_REQ_SYNC | DMA_REQ_ASYNC) & DMA_WAKE_EN;
  assign dma_wake = |dma_any_ch;
  assign bus_alive = (sel_r == SEL_BUS_ALIVE);
  assign full_stop = (sel_r == SEL_FULL_STOP);
  // Bus-alive also leaves on a bus-clocked synchronous interrupt; the others
  // only on an asynchronous one.
  assign irq_wake = IRQ[IRQ_ASYNC_SYS] || (bus_alive && IRQ[IRQ_SYNC_BUS]);
  assign entering = (state_r == ST_STOP_MASTERS) || (state_r == ST_STOP_SLAVES) ||
                    (state_r == ST_STOP_POWER);
  assign stage_active = entering;
  assign stage_ack = (state_r == ST_STOP_MASTERS) ? MASTER_ACK :
                     (state_r == ST_STOP_SLAVES) ? SLAVE_ACK : POWER_ACK;
  // The stage timer restarts in the first cycle of every state. Registering the
  // change keeps the timer's done out of the next-state loop.
  assign stage_start_nxt = (state_nxt != state_r);

  psdws_stage_timer u_timer (
    .clk(CLOCK),
    .rstn(RSTN),
    .start(stage_start_r),
    .active(stage_active),
    .ack(stage_ack),
    .done(stage_done)
  );

  // Next state.
  always_comb
  begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    compute_nxt = compute_r;
    vlp_nxt = vlp_r;
    abort_nxt = 1'b0;
    wake_nxt = 1'b0;
    unique case (state_r)
      ST_RUN:
      begin
        if (STOP_REQ || COMPUTE_OP)
        begin
          // The selection is captured here and held until exit.
          sel_nxt = STOP_SEL;
          compute_nxt = COMPUTE_OP && !STOP_REQ;
          vlp_nxt = VERY_LOW_POWER_RUN;
          state_nxt = ST_STOP_MASTERS;
        end
      end
      ST_STOP_MASTERS, ST_STOP_SLAVES, ST_STOP_POWER:
      begin
        if (irq_wake && !compute_r)
          state_nxt = ST_EXIT;
        else if (dma_wake)
        begin
          // Entry is abandoned and resumed after the wakeup drains.
          abort_nxt = 1'b1;
          state_nxt = ST_DMA_AWAKE;
        end
        else if (!STOP_REQ && !COMPUTE_OP)
          state_nxt = ST_EXIT;
        else if (stage_done)
        begin
          // Masters first, then slaves, then power only for full stop.
          if (state_r == ST_STOP_MASTERS)
            state_nxt = ST_STOP_SLAVES;
          else if (state_r == ST_STOP_SLAVES && full_stop && !compute_r)
            state_nxt = ST_STOP_POWER;
          else
            state_nxt = ST_LOW_POWER;
        end
      end
      ST_LOW_POWER:
      begin
        if (irq_wake && !(compute_r && !COMPUTE_IRQ_EXIT))
          state_nxt = ST_EXIT;
        else if (dma_wake)
          state_nxt = ST_DMA_AWAKE;
        else if (compute_r && !COMPUTE_OP)
          state_nxt = ST_EXIT;
      end
      ST_DMA_AWAKE:
      begin
        // An interrupt exits at once; the transfer keeps its clocks.
        if (irq_wake && !(compute_r && !COMPUTE_IRQ_EXIT))
          state_nxt = ST_EXIT;
        else if (!dma_wake)
          state_nxt = ST_DMA_DRAIN;
        // A request that never drops holds the woken state.
      end
      ST_DMA_DRAIN:
      begin
        if (irq_wake && !(compute_r && !COMPUTE_IRQ_EXIT))
          state_nxt = ST_EXIT;
        else if (dma_wake)
          state_nxt = ST_DMA_AWAKE;
        else if (!DMA_BUSY)
          state_nxt = ST_STOP_MASTERS;
      end
      ST_EXIT:
      begin
        wake_nxt = 1'b1;
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Output map per state and held selection.
  always_comb
  begin
    ctrl_nxt = CTRL_RUN;
    unique case (state_nxt)
      ST_RUN, ST_EXIT:
        ctrl_nxt = CTRL_RUN;
      ST_DMA_AWAKE, ST_DMA_DRAIN:
      begin
        // Everything restored except the core clock outside compute.
        ctrl_nxt = CTRL_RUN;
        ctrl_nxt.core_clk_en = compute_nxt;
      end
      ST_STOP_MASTERS:
      begin
        ctrl_nxt.core_clk_en = compute_nxt;
        ctrl_nxt.master_stop = 1'b1;
      end
      ST_STOP_SLAVES, ST_STOP_POWER, ST_LOW_POWER:
      begin
        ctrl_nxt.core_clk_en = compute_nxt;
        ctrl_nxt.master_stop = 1'b1;
        ctrl_nxt.sys_slave_stop = 1'b1;
        // Outside compute, bus-alive keeps bus slaves running on the live bus clock.
        ctrl_nxt.bus_slave_stop = !(sel_nxt == SEL_BUS_ALIVE) || compute_nxt;
        if (state_nxt == ST_STOP_POWER)
        begin
          // Generator and regulator move only once every party has acknowledged or its stage wait has run out.
          ctrl_nxt.gen_stop = 1'b1;
          ctrl_nxt.reg_stop = vlp_nxt;
        end
        if (state_nxt == ST_LOW_POWER && !compute_nxt)
        begin
          ctrl_nxt.core_clk_en = 1'b0;
          ctrl_nxt.sys_clk_en = 1'b0;
          ctrl_nxt.bus_clk_en = (sel_nxt == SEL_BUS_ALIVE);
          // Partial stop leaves generator and regulator in run.
          ctrl_nxt.gen_stop = (sel_nxt == SEL_FULL_STOP);
          ctrl_nxt.reg_stop = (sel_nxt == SEL_FULL_STOP) && vlp_nxt;
        end
      end
      default:
        ctrl_nxt = CTRL_RUN;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      state_r <= ST_RUN;
      sel_r <= SEL_FULL_STOP;
      compute_r <= 1'b0;
      vlp_r <= 1'b0;
      abort_r <= 1'b0;
      wake_r <= 1'b0;
      stage_start_r <= 1'b0;
      ctrl_r <= CTRL_RUN;
    end
    else
    begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      compute_r <= compute_nxt;
      vlp_r <= vlp_nxt;
      abort_r <= abort_nxt;
      wake_r <= wake_nxt;
      stage_start_r <= stage_start_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign CTRL = ctrl_r;
  assign LOW_POWER = (state_r == ST_LOW_POWER);
  assign DMA_AWAKE = (state_r == ST_DMA_AWAKE) || (state_r == ST_DMA_DRAIN);
  assign STOP_ABORT = abort_r;
  assign CPU_WAKE = wake_r;

  sel_held_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_r != ST_RUN && state_nxt != ST_RUN |-> sel_nxt == sel_r)
    else $error("Stop selection changed before exit");

  bus_alive_clk_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && !compute_r && sel_r == SEL_BUS_ALIVE |->
      CTRL.bus_clk_en && !CTRL.sys_clk_en && !CTRL.core_clk_en && !CTRL.bus_slave_stop)
    else $error("Bus-alive stop gated the wrong clocks");

  full_gate_clk_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && !compute_r && sel_r == SEL_FULL_GATE |->
      !CTRL.bus_clk_en && !CTRL.sys_clk_en && CTRL.master_stop && CTRL.bus_slave_stop)
    else $error("Full-gate stop left a clock or party running");

  partial_power_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    sel_r != SEL_FULL_STOP && state_r != ST_RUN |-> !CTRL.gen_stop && !CTRL.reg_stop)
    else $error("Partial stop stopped the generator or regulator");

  sync_irq_exit_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && !compute_r && sel_r == SEL_BUS_ALIVE && IRQ[IRQ_SYNC_BUS] |=>
      state_r == ST_EXIT ##1 CPU_WAKE)
    else $error("Bus interrupt did not end bus-alive stop");

  full_gate_sync_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && sel_r == SEL_FULL_GATE && !IRQ[IRQ_ASYNC_SYS] && !dma_wake &&
      !compute_r |=> LOW_POWER)
    else $error("Full-gate stop left without a valid source");

  dma_wake_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && dma_wake && !irq_wake |=> DMA_AWAKE ##1
      (CTRL.sys_clk_en && CTRL.bus_clk_en && !CTRL.master_stop && !CTRL.gen_stop))
    else $error("DMA wakeup did not restore clocks");

  core_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    DMA_AWAKE && $past(DMA_AWAKE) |-> CTRL.core_clk_en == compute_r)
    else $error("Core clock wrong during DMA wakeup");

  held_req_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_r == ST_DMA_AWAKE && dma_wake && !irq_wake |=> state_r == ST_DMA_AWAKE)
    else $error("Held DMA request lost the woken state");

  abort_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    entering && dma_wake && !(irq_wake && !compute_r) |=> STOP_ABORT && DMA_AWAKE)
    else $error("Entry not aborted by DMA request");

  reentry_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_r == ST_DMA_DRAIN && !dma_wake && !DMA_BUSY && !irq_wake |=>
      state_r == ST_STOP_MASTERS && sel_r == $past(sel_r))
    else $error("Re-entry after DMA wakeup went wrong");

  entry_take_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_r == ST_RUN && STOP_REQ |=> state_r == ST_STOP_MASTERS && CTRL.master_stop)
    else $error("Stop request did not start entry");

  slaves_after_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_r == ST_STOP_MASTERS |->
      !CTRL.sys_slave_stop && !CTRL.bus_slave_stop && !CTRL.gen_stop)
    else $error("Slaves stopped before masters");

  power_last_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_r == ST_STOP_POWER |->
      CTRL.master_stop && CTRL.sys_slave_stop && CTRL.bus_slave_stop && CTRL.gen_stop)
    else $error("Power stage reached before all parties stopped");

  chan_enable_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && !compute_r && IRQ == 2'h0 &&
      ((DMA_REQ_SYNC | DMA_REQ_ASYNC) & DMA_WAKE_EN) == '0 |=> LOW_POWER)
    else $error("Disabled channel woke the device");

  sync_dma_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LOW_POWER && |(DMA_REQ_SYNC & DMA_WAKE_EN) && !irq_wake |=> DMA_AWAKE)
    else $error("Synchronous DMA request did not wake");

  compute_core_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    compute_r && state_r != ST_RUN |-> CTRL.core_clk_en)
    else $error("Core clock stopped during compute");

  irq_dma_exit_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    DMA_AWAKE && IRQ[IRQ_ASYNC_SYS] && !compute_r |=> state_r == ST_EXIT)
    else $error("Interrupt did not end DMA wakeup");

endmodule // psdws_sequencer

/* verif/psdws_far_model.sv */
// Far-side model: masters, slaves and power parties answering stop requests.
// Assumes the sequencer CTRL struct and one shared clock.
`timescale 1ns/1ps
module psdws_far_model
  import psdws_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Stop requests and pace.
  input wire psdws_ctrl_t ctrl,
  input wire logic slow,
  // Acknowledges.
  output logic master_ack,
  output logic slave_ack,
  output logic power_ack
);
  logic [3:0] m_cnt_r;
  logic [3:0] s_cnt_r;
  logic [3:0] p_cnt_r;
  wire [3:0] lat = slow ? 4'h8 : 4'h1;
  wire s_req = ctrl.sys_slave_stop | ctrl.bus_slave_stop;
  wire p_req = ctrl.gen_stop | ctrl.reg_stop;
  // Each party answers after its latency and drops the ack once released.
  always_ff @(posedge clk)
  begin
    m_cnt_r <= (!rstn || !ctrl.master_stop) ? 4'h0 : m_cnt_r + {3'h0, m_cnt_r != 4'hf};
    s_cnt_r <= (!rstn || !s_req) ? 4'h0 : s_cnt_r + {3'h0, s_cnt_r != 4'hf};
    p_cnt_r <= (!rstn || !p_req) ? 4'h0 : p_cnt_r + {3'h0, p_cnt_r != 4'hf};
  end
  assign master_ack = m_cnt_r >= lat;
  assign slave_ack = s_cnt_r >= lat;
  assign power_ack = p_cnt_r >= lat;
endmodule // psdws_far_model

/* verif/psdws_sequencer_tb_top.sv */
// Self-checking bench for the partial stop and DMA wakeup sequencer.
// Assumes the far-side model answers the stop requests.
`timescale 1ns/1ps
module psdws_sequencer_tb_top
  import psdws_pkg::*;
;
  logic clock;
  logic rstn;
  logic stop_req;
  logic very_low_power_run;
  logic compute_op;
  logic compute_irq_exit;
  logic [1:0] stop_sel;
  logic [DMA_CHANNELS-1:0] dma_wake_en;
  logic [DMA_CHANNELS-1:0] dma_req_sync;
  logic [DMA_CHANNELS-1:0] dma_req_async;
  logic dma_busy;
  logic [1:0] irq;
  logic slow;
  logic m_ack;
  logic s_ack;
  logic p_ack;
  psdws_ctrl_t ctrl;
  logic low_power;
  logic dma_awake;
  logic stop_abort;
  logic cpu_wake;
  int errors;
  int compares;

  psdws_sequencer psdws_sequencer_inst (.CLOCK(clock), .RSTN(rstn), .STOP_REQ(stop_req),
    .VERY_LOW_POWER_RUN(very_low_power_run), .COMPUTE_OP(compute_op), .COMPUTE_IRQ_EXIT(compute_irq_exit),
    .STOP_SEL(stop_sel), .DMA_WAKE_EN(dma_wake_en), .DMA_REQ_SYNC(dma_req_sync),
    .DMA_REQ_ASYNC(dma_req_async), .DMA_BUSY(dma_busy), .IRQ(irq), .MASTER_ACK(m_ack),
    .SLAVE_ACK(s_ack), .POWER_ACK(p_ack), .CTRL(ctrl), .LOW_POWER(low_power),
    .DMA_AWAKE(dma_awake), .STOP_ABORT(stop_abort), .CPU_WAKE(cpu_wake));
  psdws_far_model psdws_far_model_inst (.clk(clock), .rstn(rstn), .ctrl(ctrl), .slow(slow),
    .master_ack(m_ack), .slave_ack(s_ack), .power_ack(p_ack));

  always #50 clock = ~clock;

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  function automatic logic flag(input int k);
    case (k)
      0: flag = low_power;
      1: flag = dma_awake;
      2: flag = stop_abort;
      default: flag = cpu_wake;
    endcase
  endfunction

  task automatic wait_flag(input int k, input int lim);
    int i;
    i = 0;
    while (flag(k) !== 1'b1 && i < lim)
    begin
      step(1);
      i++;
    end
    chk($sformatf("flag%0d", k), 8'h01, {7'h0, flag(k)});
  endtask

  task automatic leave(input logic [1:0] src);
    stop_req = 1'b0;
    irq = src;
    wait_flag(3, 20);
    irq = 2'h0;
    step(1);
    chk("ctrl", CTRL_RUN, ctrl);
  endtask

  task automatic t_bus_alive();
    stop_sel = SEL_BUS_ALIVE;
    stop_req = 1'b1;
    wait_flag(0, 60);
    chk("ctrl", 8'h38, ctrl);
    leave(2'h2);
  endtask

  task automatic t_full_gate();
    stop_sel = SEL_FULL_GATE;
    very_low_power_run = 1'b1;
    stop_req = 1'b1;
    wait_flag(0, 60);
    chk("ctrl", 8'h1c, ctrl);
    irq = 2'h2;
    step(5);
    chk("low_power", 8'h01, {7'h0, low_power});
    leave(2'h1);
    very_low_power_run = 1'b0;
  endtask

  task automatic t_dma();
    int i;
    stop_sel = SEL_FULL_GATE;
    stop_req = 1'b1;
    wait_flag(0, 60);
    dma_wake_en = 4'h4;
    dma_req_async = 4'h1;
    step(5);
    chk("low_power", 8'h01, {7'h0, low_power});
    dma_req_async = 4'h4;
    wait_flag(1, 10);
    chk("ctrl", 8'h60, ctrl);
    stop_sel = SEL_BUS_ALIVE;
    dma_busy = 1'b1;
    step(10);
    chk("dma_awake", 8'h01, {7'h0, dma_awake});
    dma_req_async = 4'h0;
    step(3);
    chk("dma_awake", 8'h01, {7'h0, dma_awake});
    dma_busy = 1'b0;
    i = 0;
    while (ctrl.master_stop !== 1'b1 && i < 20)
    begin
      step(1);
      i++;
    end
    chk("slave_stop", 8'h00, {7'h0, ctrl.sys_slave_stop});
    wait_flag(0, 60);
    chk("ctrl", 8'h1c, ctrl);
    dma_req_sync = 4'h4;
    wait_flag(1, 10);
    dma_busy = 1'b1;
    leave(2'h1);
    dma_req_sync = 4'h0;
    dma_busy = 1'b0;
  endtask

  task automatic t_abort();
    slow = 1'b1;
    stop_sel = SEL_BUS_ALIVE;
    stop_req = 1'b1;
    step(3);
    dma_req_async = 4'h4;
    wait_flag(2, 6);
    chk("dma_awake", 8'h01, {7'h0, dma_awake});
    dma_req_async = 4'h0;
    wait_flag(0, 80);
    slow = 1'b0;
    leave(2'h1);
  endtask

  task automatic t_compute();
    compute_op = 1'b1;
    wait_flag(0, 60);
    chk("core_clk", 8'h01, {7'h0, ctrl.core_clk_en});
    irq = 2'h1;
    step(4);
    chk("low_power", 8'h01, {7'h0, low_power});
    irq = 2'h0;
    dma_req_sync = 4'h4;
    wait_flag(1, 10);
    chk("ctrl", CTRL_RUN, ctrl);
    dma_req_sync = 4'h0;
    wait_flag(0, 60);
    compute_irq_exit = 1'b1;
    irq = 2'h1;
    wait_flag(3, 20);
    compute_op = 1'b0;
    compute_irq_exit = 1'b0;
    irq = 2'h0;
    step(1);
    chk("ctrl", CTRL_RUN, ctrl);
    compute_op = 1'b1;
    wait_flag(0, 60);
    compute_op = 1'b0;
    wait_flag(3, 20);
  endtask

  task automatic t_full_stop();
    int i;
    stop_sel = SEL_FULL_STOP;
    very_low_power_run = 1'b1;
    dma_wake_en = 4'h4;
    stop_req = 1'b1;
    i = 0;
    while (ctrl.gen_stop !== 1'b1 && i < 40)
    begin
      step(1);
      i++;
    end
    chk("power_stage", 8'h01, {7'h0, ctrl.master_stop & ctrl.bus_slave_stop & !low_power});
    wait_flag(0, 20);
    chk("ctrl", 8'h1f, ctrl);
    dma_req_async = 4'h4;
    wait_flag(1, 10);
    chk("ctrl", 8'h60, ctrl);
    dma_req_async = 4'h0;
    wait_flag(0, 60);
    chk("ctrl", 8'h1f, ctrl);
    leave(2'h1);
    very_low_power_run = 1'b0;
  endtask

  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #2_000_000;
    errors++;
    test_done();
  end

  initial
  begin
    {clock, rstn, stop_req, very_low_power_run, compute_op, compute_irq_exit, stop_sel, dma_busy} = '0;
    {dma_wake_en, dma_req_sync, dma_req_async, irq, slow} = '0;
    errors = 0;
    compares = 0;
    step(4);
    rstn = 1'b1;
    chk("ctrl", CTRL_RUN, ctrl);
    chk("status", 8'h00, {4'h0, low_power, dma_awake, stop_abort, cpu_wake});
    t_bus_alive();
    t_full_gate();
    t_dma();
    t_full_stop();
    t_abort();
    t_compute();
    test_done();
  end
endmodule // psdws_sequencer_tb_top
